// ==== rtl/flash_driver_status_control.sv ====
/*
 * Control and status logic of an LED flash boost driver: power-good
 * qualification, thermal flags, torch pin, blanking, undervoltage gating,
 * indicator PWM and torch watchdog.
 * Assumes analog comparator results arrive synchronous to clk_in.
 */
`timescale 1ns/10ps
module flash_driver_status_control #(
	parameter longint unsigned WDOG_CYC = flash_ctl_pkg::WDOG_CYC_L
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       hw_reset_n_in,
	input  wire logic [1:0] mode_wr_data_in,
	input  wire logic       mode_wr_in,
	input  wire logic       pg_output_type_in,
	input  wire logic       thermistor_enable_in,
	input  wire logic [3:0] indicator_level_in,
	input  wire logic [2:0] led_channel_enable_in,
	input  wire logic       storage_cap_select_in,
	input  wire logic       voltage_mode_pin_in,
	input  wire logic       torch_enable_pin_in,
	input  wire logic       blanking_in,
	input  wire logic       vout_in_window_in,
	input  wire logic       reverse_active_in,
	input  wire logic       ts_below_warm_in,
	input  wire logic       ts_below_hot_in,
	input  wire logic [1:0] junction_level_in,
	input  wire logic       undervoltage_in,
	output logic [1:0]      mode_out,
	output logic            supply_ok_status_out,
	output logic            supply_ok_pin_o_out,
	output logic            supply_ok_pin_oe_out,
	output flash_ctl_pkg::temp_status_t temp_status_out,
	output logic [2:0]      led_on_out,
	output logic            flash_current_out,
	output logic            low_current_limit_out,
	output logic            switches_enable_out,
	output logic            vout_pulldown_out,
	output logic            watchdog_expired_out
);
	logic        rst;
	logic [1:0]  mode_q;
	logic [1:0]  mode_d;
	logic        pg_q;
	flash_ctl_pkg::temp_status_t temp_q;
	flash_ctl_pkg::temp_status_t temp_d;
	logic [2:0]  led_q;
	logic        flash_q;
	logic        ilim_q;
	logic        sw_q;
	logic        pull_q;
	logic        pin_o_q;
	logic        pin_oe_q;
	logic        wd_exp_q;
	logic [31:0] slot_cnt_q;
	logic [3:0]  pwm_pos_q;
	logic [63:0] wd_cnt_q;

	// reset pin acts as a synchronous reset of all control state.
	assign rst = rst_in | ~hw_reset_n_in;

	wire volt_mode  = (mode_q == flash_ctl_pkg::MODE_VOLT) |
	                  voltage_mode_pin_in;
	wire shutdown   = (mode_q == flash_ctl_pkg::MODE_OFF) &
	                  ~torch_enable_pin_in & ~voltage_mode_pin_in;
	wire led_mode   = (mode_q == flash_ctl_pkg::MODE_TORCH) |
	                  (mode_q == flash_ctl_pkg::MODE_FLASH);
	wire pin_torch  = torch_enable_pin_in &
	                  ((mode_q == flash_ctl_pkg::MODE_OFF) | volt_mode) &
	                  (indicator_level_in == flash_ctl_pkg::IND_OFF);
	// dimming only in software torch mode.
	wire sw_torch   = (mode_q == flash_ctl_pkg::MODE_TORCH) &
	                  ~torch_enable_pin_in;
	wire dimming    = sw_torch &
	                  (indicator_level_in != flash_ctl_pkg::IND_OFF);
	wire ts_active  = led_mode | pin_torch |
	                  ((mode_q == flash_ctl_pkg::MODE_VOLT) &
	                   thermistor_enable_in);
	wire regulating = led_mode | pin_torch;
	// overheat event while regulating LED current.
	wire hot_event  = ts_active & regulating & ts_below_hot_in;
	// PWM on while position below indicator level.
	wire pwm_on     = pwm_pos_q < indicator_level_in;
	// watchdog runs only for software torch not excluded.
	wire wd_run     = sw_torch & ~dimming & ~wd_exp_q;
	wire wd_done    = wd_run & (wd_cnt_q == WDOG_CYC - 64'h1);
	wire pg_d       = volt_mode & vout_in_window_in & ~reverse_active_in;
	wire sw_d       = ~undervoltage_in & ~shutdown;
	wire [2:0] led_d = (regulating & ~wd_exp_q &
	                    (~dimming | pwm_on) & ~hot_event) ?
	                   led_channel_enable_in : 3'h0;

	always_comb begin
		mode_d = mode_q;
		if (mode_wr_in) begin
			mode_d = mode_wr_data_in;
		end
		if (hot_event) begin
			mode_d = flash_ctl_pkg::MODE_OFF;
		end
	end

	always_comb begin
		temp_d = temp_q;
		temp_d.warm = ts_active & ts_below_warm_in;
		// junction level except in full shutdown.
		temp_d.junction = shutdown ? 2'h0 : junction_level_in;
		// overheat latches and forces junction bits.
		if (hot_event | temp_q.overheat) begin
			temp_d.overheat = 1'b1;
			temp_d.junction = flash_ctl_pkg::TEMP_HOT;
		end
	end

	wire pin_o_d  = pg_output_type_in ? 1'b0 : (shutdown ? 1'b0 : pg_d);
	wire pin_oe_d = pg_output_type_in ? (~shutdown & pg_d) : 1'b1;

	always_ff @(posedge clk_in) begin
		if (rst) begin
			mode_q   <= flash_ctl_pkg::MODE_OFF;
			pg_q     <= 1'b0;
			temp_q   <= '0;
			led_q    <= 3'h0;
			flash_q  <= 1'b0;
			ilim_q   <= 1'b0;
			sw_q     <= 1'b0;
			pull_q   <= 1'b0;
			pin_o_q  <= 1'b0;
			pin_oe_q <= 1'b1;
		end else begin
			mode_q   <= mode_d;
			pg_q     <= pg_d;
			temp_q   <= temp_d;
			led_q    <= led_d;
			// flash current unless pin torch or blanked without storage cap.
			flash_q  <= (mode_q == flash_ctl_pkg::MODE_FLASH) &
			            ~pin_torch & ~(blanking_in & ~storage_cap_select_in);
			// blanking steers current limit in storage mode.
			ilim_q   <= storage_cap_select_in & blanking_in;
			sw_q     <= sw_d;
			pull_q   <= shutdown & ~storage_cap_select_in;
			pin_o_q  <= pin_o_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	// PWM slots derived by dividing the clock.
	always_ff @(posedge clk_in) begin
		if (rst) begin
			slot_cnt_q <= 32'h0;
			pwm_pos_q  <= 4'h0;
		end else if (slot_cnt_q ==
		             32'(flash_ctl_pkg::PWM_SLOT_CYC - 1)) begin
			slot_cnt_q <= 32'h0;
			pwm_pos_q  <= pwm_pos_q + 4'h1;
		end else begin
			slot_cnt_q <= slot_cnt_q + 32'h1;
		end
	end

	// watchdog, not started by torch pin.
	always_ff @(posedge clk_in) begin
		if (rst || !sw_torch) begin
			wd_cnt_q <= 64'h0;
			wd_exp_q <= 1'b0;
		end else if (wd_done) begin
			wd_exp_q <= 1'b1;
		end else if (wd_run) begin
			wd_cnt_q <= wd_cnt_q + 64'h1;
		end
	end

	assign mode_out              = mode_q;
	assign supply_ok_status_out  = pg_q;
	assign supply_ok_pin_o_out   = pin_o_q;
	assign supply_ok_pin_oe_out  = pin_oe_q;
	assign temp_status_out       = temp_q;
	assign led_on_out            = led_q;
	assign flash_current_out     = flash_q;
	assign low_current_limit_out = ilim_q;
	assign switches_enable_out   = sw_q;
	assign vout_pulldown_out     = pull_q;
	assign watchdog_expired_out  = wd_exp_q;

	pg_volt_only_a: assert property (
		@(posedge clk_in) disable iff (rst)
		supply_ok_status_out |-> $past(volt_mode))
		else $error("power good outside voltage mode");

	pg_window_a: assert property (
		@(posedge clk_in) disable iff (rst)
		!vout_in_window_in |=> !supply_ok_status_out)
		else $error("power good outside output window");

	pg_suspend_low_a: assert property (
		@(posedge clk_in) disable iff (rst)
		!volt_mode |=> !supply_ok_status_out)
		else $error("power good high while voltage mode suspended");

	pg_reverse_a: assert property (
		@(posedge clk_in) disable iff (rst)
		reverse_active_in |=> !supply_ok_status_out)
		else $error("power good during reverse operation");

	pp_shutdown_a: assert property (
		@(posedge clk_in) disable iff (rst)
		shutdown && !pg_output_type_in |=>
		supply_ok_pin_oe_out && !supply_ok_pin_o_out)
		else $error("push-pull pin not low in shutdown");

	pg_push_pull_a: assert property (
		@(posedge clk_in) disable iff (rst)
		!pg_output_type_in && !shutdown |=>
		supply_ok_pin_oe_out &&
		supply_ok_pin_o_out == supply_ok_status_out)
		else $error("push-pull pin not following status");

	pg_open_drain_a: assert property (
		@(posedge clk_in) disable iff (rst)
		pg_output_type_in |=> !supply_ok_pin_o_out &&
		supply_ok_pin_oe_out == supply_ok_status_out)
		else $error("open-drain pin not pulling low on status");

	ts_idle_a: assert property (
		@(posedge clk_in) disable iff (rst)
		!ts_active |=> !temp_status_out.warm)
		else $error("warm flag while thermistor not monitored");

	warm_set_a: assert property (
		@(posedge clk_in) disable iff (rst)
		ts_active && ts_below_warm_in |=> temp_status_out.warm)
		else $error("warm flag not set");

	hot_shutdown_a: assert property (
		@(posedge clk_in) disable iff (rst)
		hot_event |=> mode_out == flash_ctl_pkg::MODE_OFF &&
		temp_status_out.overheat &&
		temp_status_out.junction == flash_ctl_pkg::TEMP_HOT)
		else $error("overheat did not suspend operation");

	junction_live_a: assert property (
		@(posedge clk_in) disable iff (rst)
		!shutdown && !temp_status_out.overheat && !hot_event |=>
		temp_status_out.junction == $past(junction_level_in))
		else $error("junction level not reported");

	hw_reset_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!hw_reset_n_in |=> mode_out == flash_ctl_pkg::MODE_OFF &&
		temp_status_out == '0)
		else $error("reset pin did not restore defaults");

	pin_no_timer_a: assert property (
		@(posedge clk_in) disable iff (rst)
		torch_enable_pin_in |=> !watchdog_expired_out)
		else $error("watchdog active under torch pin");

	pin_torch_on_a: assert property (
		@(posedge clk_in) disable iff (rst)
		pin_torch && !hot_event && !watchdog_expired_out |=>
		led_on_out == $past(led_channel_enable_in))
		else $error("torch pin did not light enabled channels");

	pin_refused_a: assert property (
		@(posedge clk_in) disable iff (rst)
		torch_enable_pin_in && !led_mode &&
		indicator_level_in != flash_ctl_pkg::IND_OFF |=>
		led_on_out == 3'h0)
		else $error("torch pin honoured with indicator on");

	blank_torch_a: assert property (
		@(posedge clk_in) disable iff (rst)
		blanking_in && !storage_cap_select_in |=>
		!flash_current_out)
		else $error("flash current while blanked");

	ilim_follow_a: assert property (
		@(posedge clk_in) disable iff (rst)
		storage_cap_select_in |=>
		low_current_limit_out == $past(blanking_in))
		else $error("current limit not following blanking");

	uv_gate_a: assert property (
		@(posedge clk_in) disable iff (rst)
		undervoltage_in |=> !switches_enable_out)
		else $error("switches enabled under undervoltage");

	pulldown_a: assert property (
		@(posedge clk_in) disable iff (rst)
		vout_pulldown_out |->
		$past(shutdown) && !$past(storage_cap_select_in))
		else $error("pulldown outside full shutdown");

	dim_gate_a: assert property (
		@(posedge clk_in) disable iff (rst)
		dimming && !pwm_on |=> led_on_out == 3'h0)
		else $error("leds on in off part of dimming period");

	dim_sw_only_a: assert property (
		@(posedge clk_in) disable iff (rst)
		led_mode && !sw_torch && !hot_event &&
		!watchdog_expired_out |=>
		led_on_out == $past(led_channel_enable_in))
		else $error("dimming outside software torch mode");

	wdog_off_a: assert property (
		@(posedge clk_in) disable iff (rst)
		watchdog_expired_out |=> led_on_out == 3'h0)
		else $error("leds on after watchdog expiry");

	slot_range_a: assert property (
		@(posedge clk_in) disable iff (rst)
		slot_cnt_q < 32'(flash_ctl_pkg::PWM_SLOT_CYC))
		else $error("pwm slot counter out of range");

	cover_pg: cover property (@(posedge clk_in) disable iff (rst)
		$rose(supply_ok_status_out));
	cover_hot: cover property (@(posedge clk_in) disable iff (rst)
		hot_event);
	cover_dim: cover property (@(posedge clk_in) disable iff (rst)
		dimming ##1 led_on_out != 3'h0);
	cover_wdog: cover property (@(posedge clk_in) disable iff (rst)
		$rose(watchdog_expired_out));
endmodule

// ==== rtl/flash_ctl_pkg.sv ====
/*
 * Package for the flash driver control and status block: mode codes,
 * timing constants and the carrier structs for the status outputs.
 * Assumes a 100 MHz block clock derived from the internal oscillator.
 */
package flash_ctl_pkg;
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_TORCH = 2'h1;
	localparam logic [1:0] MODE_FLASH = 2'h2;
	localparam logic [1:0] MODE_VOLT  = 2'h3;
	localparam logic [3:0] IND_OFF    = 4'h0;
	localparam logic [1:0] TEMP_HOT   = 2'h3;

	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned PWM_HZ      = 122;
	// Sixteen duty slots per PWM period.
	localparam int unsigned PWM_SLOTS   = 16;
	localparam int unsigned PWM_SLOT_CYC = CLK_HZ / (PWM_HZ * PWM_SLOTS);
	// Torch watchdog is 11.2 s, kept in milliseconds.
	localparam int unsigned WDOG_MS     = 11200;
	localparam longint unsigned WDOG_CYC_L =
		longint'(WDOG_MS) * longint'(CLK_HZ / 1000);

	typedef struct packed {
		logic       warm;
		logic       overheat;
		logic [1:0] junction;
	} temp_status_t;

	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;
endpackage

// ==== dv/flash_host_model.sv ====
/*
 * Model of the host controller that drives the pins of the flash driver
 * control block: reset pin, voltage-mode pin, torch pin and blanking.
 * Assumes one clock, shared with the block, and calls from the bench.
 */
`timescale 1ns/10ps
module flash_host_model (
	input  wire logic clk_in,
	output logic      hw_reset_n_out,
	output logic      voltage_mode_pin_out,
	output logic      torch_enable_pin_out,
	output logic      blanking_out
);
	initial begin
		hw_reset_n_out = 1'h1;
		voltage_mode_pin_out = 1'h0;
		torch_enable_pin_out = 1'h0;
		blanking_out = 1'h0;
	end
	task automatic pins(input logic vm, input logic tp, input logic bl);
		@(posedge clk_in) begin
			voltage_mode_pin_out <= vm;
			torch_enable_pin_out <= tp;
			blanking_out <= bl;
		end
	endtask
	task automatic pulse_reset();
		@(posedge clk_in) hw_reset_n_out <= 1'h0;
		@(posedge clk_in) hw_reset_n_out <= 1'h1;
	endtask
endmodule

// ==== dv/flash_driver_status_control_bench.sv ====
/*
 * Self-checking bench for the flash driver control and status block.
 * Assumes the registered one-cycle answer of the block and a shortened
 * torch watchdog of 200 cycles.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
	begin samples_checked++; if ((got) !== (ex)) begin \
	$display("wrong value %s exp %0h got %0h", nm, ex, got); \
	err_total++; end end
module flash_driver_status_control_bench;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, pgt = 1'h0, tse = 1'h0;
	logic stor = 1'h0, win = 1'h0, rev = 1'h0, wrm = 1'h0, hot = 1'h0;
	logic uv = 1'h0, nrst, vm, tp, bl;
	logic [1:0] wd = 2'h0, jl = 2'h0, mode;
	logic [3:0] ind = 4'h0;
	logic [2:0] led = 3'h0, on;
	logic st, po, poe, fc, lcl, sw, pd, wde;
	flash_ctl_pkg::temp_status_t ts;
	int err_total = 0, samples_checked = 0, cyc = 0;
	always #5 clk = ~clk;
	flash_host_model host_u (.clk_in(clk), .hw_reset_n_out(nrst),
		.voltage_mode_pin_out(vm), .torch_enable_pin_out(tp),
		.blanking_out(bl));
	flash_driver_status_control #(.WDOG_CYC(200)) dut_u (.clk_in(clk),
		.rst_in(rst), .hw_reset_n_in(nrst), .mode_wr_data_in(wd),
		.mode_wr_in(wr), .pg_output_type_in(pgt),
		.thermistor_enable_in(tse), .indicator_level_in(ind),
		.led_channel_enable_in(led), .storage_cap_select_in(stor),
		.voltage_mode_pin_in(vm), .torch_enable_pin_in(tp),
		.blanking_in(bl), .vout_in_window_in(win),
		.reverse_active_in(rev), .ts_below_warm_in(wrm),
		.ts_below_hot_in(hot), .junction_level_in(jl),
		.undervoltage_in(uv), .mode_out(mode),
		.supply_ok_status_out(st), .supply_ok_pin_o_out(po),
		.supply_ok_pin_oe_out(poe), .temp_status_out(ts),
		.led_on_out(on), .flash_current_out(fc),
		.low_current_limit_out(lcl), .switches_enable_out(sw),
		.vout_pulldown_out(pd), .watchdog_expired_out(wde));
	task automatic go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wm(input logic [1:0] m);
		@(posedge clk) begin
			wr <= 1'h1;
			wd <= m;
		end
		@(posedge clk) wr <= 1'h0;
		go(2);
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A hang is cut short after a fixed budget of cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			results();
		end
	end
	initial begin
		go(1);
		@(posedge clk) rst <= 1'h0;
		go(1);
		`CHK("mode", 2'h0, mode)
		`CHK("pg_oe", 1'h1, poe)
		wm(flash_ctl_pkg::MODE_VOLT);
		@(posedge clk) win <= 1'h1;
		go(3);
		`CHK("pg", 1'h1, st)
		`CHK("pg_pin", 1'h1, po)
		@(posedge clk) pgt <= 1'h1;
		go(3);
		`CHK("pg_od_o", 1'h0, po)
		`CHK("pg_od_oe", 1'h1, poe)
		@(posedge clk) win <= 1'h0;
		go(3);
		`CHK("pg_out", 1'h0, st)
		`CHK("pg_od_rel", 1'h0, poe)
		@(posedge clk) begin
			win <= 1'h1;
			rev <= 1'h1;
		end
		go(3);
		`CHK("pg_rev", 1'h0, st)
		@(posedge clk) rev <= 1'h0;
		wm(flash_ctl_pkg::MODE_OFF);
		go(1);
		`CHK("pg_off", 1'h0, st)
		`CHK("pg_sd_od", 1'h0, poe)
		@(posedge clk) pgt <= 1'h0;
		go(3);
		`CHK("pg_sd_pp", 2'h1, {po, poe})
		host_u.pins(1'h1, 1'h0, 1'h0);
		go(3);
		`CHK("pg_vpin", 1'h1, st)
		wm(flash_ctl_pkg::MODE_VOLT);
		@(posedge clk) wrm <= 1'h1;
		go(3);
		`CHK("warm_vm", 1'h0, ts.warm)
		@(posedge clk) tse <= 1'h1;
		go(3);
		`CHK("warm_ts", 1'h1, ts.warm)
		host_u.pins(1'h0, 1'h0, 1'h0);
		wm(flash_ctl_pkg::MODE_TORCH);
		@(posedge clk) jl <= 2'h2;
		go(3);
		`CHK("junction", 2'h2, ts.junction)
		`CHK("warm_run", 2'h1, mode)
		@(posedge clk) hot <= 1'h1;
		go(3);
		`CHK("overheat", 1'h1, ts.overheat)
		`CHK("mode_hot", 2'h0, mode)
		@(posedge clk) begin
			hot <= 1'h0;
			wrm <= 1'h0;
		end
		host_u.pulse_reset();
		go(3);
		`CHK("hot_clr", 1'h0, ts.overheat)
		`CHK("junc_sd", 2'h0, ts.junction)
		`CHK("pulldn_sd", 1'h1, pd)
		@(posedge clk) led <= 3'h5;
		host_u.pins(1'h0, 1'h1, 1'h0);
		go(3);
		`CHK("torch_pin", 3'h5, on)
		@(posedge clk) ind <= 4'h1;
		go(3);
		`CHK("torch_ref", 3'h0, on)
		@(posedge clk) ind <= 4'h0;
		host_u.pins(1'h0, 1'h0, 1'h0);
		wm(flash_ctl_pkg::MODE_FLASH);
		go(1);
		`CHK("flash", 1'h1, fc)
		host_u.pins(1'h0, 1'h0, 1'h1);
		go(3);
		`CHK("blank", 1'h0, fc)
		`CHK("ilim_dd", 1'h0, lcl)
		@(posedge clk) stor <= 1'h1;
		go(3);
		`CHK("ilim", 1'h1, lcl)
		`CHK("blank_hc", 1'h1, fc)
		`CHK("pulldn", 1'h0, pd)
		`CHK("sw_on", 1'h1, sw)
		@(posedge clk) uv <= 1'h1;
		go(3);
		`CHK("sw_uv", 1'h0, sw)
		@(posedge clk) begin
			uv <= 1'h0;
			stor <= 1'h0;
			led <= 3'h7;
		end
		host_u.pins(1'h0, 1'h0, 1'h0);
		wm(flash_ctl_pkg::MODE_OFF);
		wm(flash_ctl_pkg::MODE_TORCH);
		`CHK("sw_torch", 3'h7, on)
		go(205);
		`CHK("wdog_exp", 1'h1, wde)
		`CHK("wdog_off", 3'h0, on)
		wm(flash_ctl_pkg::MODE_OFF);
		@(posedge clk) ind <= 4'h1;
		wm(flash_ctl_pkg::MODE_TORCH);
		go(210);
		`CHK("dim_wdog", 1'h0, wde)
		`CHK("dim_slot0", 3'h7, on)
		go(flash_ctl_pkg::PWM_SLOT_CYC);
		`CHK("dim_slot1", 3'h0, on)
		results();
	end
endmodule
